// ---- src/usart_baud_clock_generator.sv ----
// Operation
// - One bit clock feeds receiver and transmitter
// - Source: master, master divided, or pin
// - Sixteen-bit divider set by baud divisor
// - Divisor zero stops baud output except sync with pin source code 3
// - Divisor one bypasses the divider
// - Async: divider output samples, then /16 or /8
// - Over bit picks 8x or 16x sampling
// - Async rate is source over 8(2-over)divisor
// - Gated clock resumes from held state
// - Configuration accepted while clock gated
// - Sync: baud is source over divisor only
// - Sync with pin source code 3 ignores divisor
module usart_baud_clock_generator
   import baud_gen_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic periph_clk_en,   // Gate for the peripheral clock
   input wire logic cfg_wr,          // Configuration write strobe
   input wire baud_cfg_t cfg_in,     // Configuration written on cfg_wr
   input wire logic serial_clk_in,   // Serial clock pin, asynchronous
   output baud_out_t ticks           // Sampling and bit clock enables
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      baud_cfg_t cfg;                // Held configuration
      logic [1:0] pin_sync;          // Pin synchroniser
      logic pin_last;                // Previous synchronised pin level
      logic [2:0] pre_cnt;           // Fixed pre-divider count
      logic [DIV_W-1:0] div_cnt;     // Programmable divider count
      logic [3:0] ovs_cnt;           // Oversampling count
      baud_out_t out;                // Registered tick outputs
   } state_t;

   state_t state_r;
   state_t state_nxt;
   logic src_tick;                   // One-cycle tick of selected source
   logic div_tick;                   // Divider output tick
   logic pin_rise;                   // Rising edge of synchronised pin

   // Pin drives the bit clock directly: sync mode with source code 3
   // Shared by the divider bypass and its check so the two cannot drift
   function automatic logic pin_direct(input baud_cfg_t c);
      return c.sync_mode && (c.clock_source_select == SRC_EXT);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      state_nxt = state_r;
      src_tick = 1'b0;
      div_tick = 1'b0;
      pin_rise = 1'b0;
      state_nxt.out = '0;
      // config while gated
      // Writes land regardless of the gate so setup needs no clock enable
      if (cfg_wr) begin
         state_nxt.cfg = cfg_in;
      end
      // Synchroniser keeps running; only its second stage is read
      state_nxt.pin_sync = {state_r.pin_sync[0], serial_clk_in};
      // hold when gated
      // With the gate off, counters freeze and resume where they stopped
      if (periph_clk_en) begin
         state_nxt.pin_last = state_r.pin_sync[1];
         pin_rise = state_r.pin_sync[1] & ~state_r.pin_last;
         if (state_r.cfg.clock_source_select == SRC_MASTER) begin
            src_tick = 1'b1;
         end else if (state_r.cfg.clock_source_select == SRC_MASTER_DIV) begin
            if (state_r.pre_cnt == 3'(MASTER_DIV - 1)) begin
               state_nxt.pre_cnt = 3'h0;
               src_tick = 1'b1;
            end else begin
               state_nxt.pre_cnt = state_r.pre_cnt + 3'h1;
            end
         end else begin
            // Pin edges: pin must stay well below mclk for this to hold
            src_tick = pin_rise;
         end
         if (pin_direct(state_r.cfg)) begin
            div_tick = src_tick;
         end else if (state_r.cfg.baud_divisor == DIV_OFF) begin
            div_tick = 1'b0;
            state_nxt.div_cnt = '0;
         end else if (state_r.cfg.baud_divisor == DIV_BYPASS) begin
            div_tick = src_tick;
         end else if (src_tick) begin
            if (state_r.div_cnt >= state_r.cfg.baud_divisor - DIV_BYPASS) begin
               state_nxt.div_cnt = '0;
               div_tick = 1'b1;
            end else begin
               state_nxt.div_cnt = state_r.div_cnt + DIV_BYPASS;
            end
         end
         if (state_r.cfg.sync_mode) begin
            state_nxt.out.baud_tick = div_tick;
            state_nxt.out.sample_tick = div_tick;
         end else begin
            state_nxt.out.sample_tick = div_tick;
            if (div_tick) begin
               if (state_r.ovs_cnt >= (state_r.cfg.over8 ? OVS_LAST_8 : OVS_LAST_16)) begin
                  state_nxt.ovs_cnt = 4'h0;
                  state_nxt.out.baud_tick = 1'b1;
               end else begin
                  state_nxt.ovs_cnt = state_r.ovs_cnt + 4'h1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign ticks = state_r.out;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // Steady 8x async setup on the undivided master clock
   sequence s_fast;
      periph_clk_en && !state_r.cfg.sync_mode && state_r.cfg.over8
      && state_r.cfg.clock_source_select == SRC_MASTER
      && state_r.cfg.baud_divisor == DIV_BYPASS;
   endsequence

   // Running on the fixed pre-divided master clock
   sequence s_mdiv;
      periph_clk_en && state_r.cfg.clock_source_select == SRC_MASTER_DIV;
   endsequence

   property p_zero_off;
      @(posedge mclk) disable iff (sys_rst)
      (state_r.cfg.baud_divisor == DIV_OFF && !state_r.cfg.sync_mode) |=> !ticks.sample_tick;
   endproperty
   a_zero_off: assert property (p_zero_off) else $error("tick with divisor zero");

   property p_bypass;
      @(posedge mclk) disable iff (sys_rst)
      (periph_clk_en && !cfg_wr && state_r.cfg.baud_divisor == DIV_BYPASS
       && state_r.cfg.clock_source_select == SRC_MASTER) |=> ticks.sample_tick;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass did not pass source");

   property p_gate_hold;
      @(posedge mclk) disable iff (sys_rst)
      !periph_clk_en |=> (state_r.div_cnt == $past(state_r.div_cnt)) && !ticks.baud_tick;
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("state moved while gated");

   property p_cfg_gated;
      @(posedge mclk) disable iff (sys_rst)
      cfg_wr |=> state_r.cfg == $past(cfg_in);
   endproperty
   a_cfg_gated: assert property (p_cfg_gated) else $error("config write lost");

   property p_baud_needs_sample;
      @(posedge mclk) disable iff (sys_rst)
      ticks.baud_tick |-> ticks.sample_tick;
   endproperty
   a_baud_needs_sample: assert property (p_baud_needs_sample) else $error("baud alone");

   // 8x count range
   // Looked at on divider ticks only: a switch from 16x may leave a high
   // count standing until the next divider tick reloads it
   property p_ovs_range;
      @(posedge mclk) disable iff (sys_rst)
      (periph_clk_en && div_tick && !cfg_wr && !state_r.cfg.sync_mode && state_r.cfg.over8)
         |=> state_r.ovs_cnt <= OVS_LAST_8;
   endproperty
   a_ovs_range: assert property (p_ovs_range) else $error("8x count overran");

   // divider below divisor
   // Looked at on source ticks only: a lowered divisor leaves a high count
   // that the next source tick reloads, so idle cycles may still show it
   property p_div_range;
      @(posedge mclk) disable iff (sys_rst)
      (periph_clk_en && src_tick && !cfg_wr && state_r.cfg.baud_divisor > DIV_BYPASS
       && !pin_direct(state_r.cfg)) |=> state_r.div_cnt < state_r.cfg.baud_divisor;
   endproperty
   a_div_range: assert property (p_div_range) else $error("divider past divisor");

   property p_sync_equal;
      @(posedge mclk) disable iff (sys_rst)
      (state_r.cfg.sync_mode && !cfg_wr) |=> ticks.baud_tick == ticks.sample_tick;
   endproperty
   a_sync_equal: assert property (p_sync_equal) else $error("sync oversampled");

   // pre-divider period
   // Repetition count is the pre-divider ratio; keep the two in step
   property p_mdiv_period;
      @(posedge mclk) disable iff (sys_rst)
      (src_tick ##0 s_mdiv ##1 s_mdiv [*8]) |-> src_tick;
   endproperty
   a_mdiv_period: assert property (p_mdiv_period) else $error("pre-divider period");

   // 8x bit period
   // Divisor one at 8x: a bit lasts eight master cycles, counted from a
   // baud tick that itself came out of the async stage
   property p_baud_every8;
      @(posedge mclk) disable iff (sys_rst)
      (s_fast ##1 ticks.baud_tick ##0 s_fast [*8]) |=> ticks.baud_tick;
   endproperty
   a_baud_every8: assert property (p_baud_every8) else $error("8x bit period wrong");

   // pin ignores divisor
   // Divisor zero silences every other path; here each pin edge still ticks
   property p_pin_direct;
      @(posedge mclk) disable iff (sys_rst)
      (periph_clk_en && pin_rise && pin_direct(state_r.cfg)
       && state_r.cfg.baud_divisor == DIV_OFF) |=> ticks.sample_tick && ticks.baud_tick;
   endproperty
   a_pin_direct: assert property (p_pin_direct) else $error("pin edge dropped");

endmodule // usart_baud_clock_generator

// ---- src/baud_gen_pkg.sv ----
package baud_gen_pkg;

   // Clock source select codes
   localparam logic [1:0] SRC_MASTER = 2'h0;
   localparam logic [1:0] SRC_MASTER_DIV = 2'h1;
   localparam logic [1:0] SRC_EXT_ALT = 2'h2;
   localparam logic [1:0] SRC_EXT = 2'h3;

   // Fixed pre-divider of the master clock, product dependent
   localparam int MASTER_DIV = 8;
   // Oversampling ratios
   localparam logic [3:0] OVS_LAST_16 = 4'hF;
   localparam logic [3:0] OVS_LAST_8 = 4'h7;
   // Divisor width and special divisor values
   localparam int DIV_W = 16;
   localparam logic [15:0] DIV_OFF = 16'h0000;
   localparam logic [15:0] DIV_BYPASS = 16'h0001;

   // Configuration carried into the generator
   typedef struct packed {
      logic [1:0] clock_source_select;
      logic over8;
      logic sync_mode;
      logic [15:0] baud_divisor;
   } baud_cfg_t;

   // Generator outputs
   typedef struct packed {
      logic sample_tick;
      logic baud_tick;
   } baud_out_t;

endpackage : baud_gen_pkg

// ---- sim/ext_clk_src.sv ----
// Far-side serial clock source, free running while run is high
module ext_clk_src (
   input wire logic run,
   output logic sck
);
   timeunit 1ns;
   timeprecision 1ps;
   // long levels, slow rate
   // Half period is 20 master cycles, far under the 4.5x limit
   // Generator raises no interrupt; nothing here to detect
   initial begin
      sck = 1'b0;
      forever begin
         #160;
         if (run) sck = ~sck;
      end
   end
endmodule // ext_clk_src

// ---- sim/test_usart_baud_clock_generator.sv ----
module test_usart_baud_clock_generator;
   timeunit 1ns;
   timeprecision 1ps;
   import baud_gen_pkg::*;
   logic mclk, sys_rst, periph_clk_en, cfg_wr, pin, run, win_go, win_end;
   baud_cfg_t cfg_in;
   baud_out_t ticks;
   logic [15:0] ns, nb; // Tick counts in the window
   logic [31:0] q[$]; // Expected counts, oldest first
   logic [7:0] lf; // Random state
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   usart_baud_clock_generator i_dut (.mclk(mclk), .sys_rst(sys_rst),
      .periph_clk_en(periph_clk_en), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
      .serial_clk_in(pin), .ticks(ticks));
   ext_clk_src i_src (.run(run), .sck(pin));
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic setcfg(input logic [1:0] s, input logic o, input logic y,
      input logic [15:0] d);
      cfg_in <= '{s, o, y, d};
      cfg_wr <= 1'b1;
      @(posedge mclk);
      cfg_wr <= 1'b0;
      repeat (400) @(posedge mclk);
   endtask
   // Window of 1280 cycles, a whole number of every tick period used
   task automatic measure(input logic [15:0] es, input logic [15:0] eb);
      win_go <= 1'b1;
      @(posedge mclk);
      win_go <= 1'b0;
      repeat (1279) @(posedge mclk);
      q.push_back({es, eb});
      win_end <= 1'b1;
      @(posedge mclk);
      win_end <= 1'b0;
   endtask
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Monitor: count ticks, compare against the oldest note
   always @(posedge mclk) begin
      ns = win_go ? 16'h0000 : ns + 16'(ticks.sample_tick);
      nb = win_go ? 16'h0000 : nb + 16'(ticks.baud_tick);
      if (win_end && q.size() > 0) begin
         check(ns, q[0][31:16]);
         check(nb, q[0][15:0]);
         void'(q.pop_front());
      end
   end
   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      sys_rst = 1'b1;
      periph_clk_en = 1'b1;
      cfg_wr = 1'b0;
      cfg_in = '0;
      run = 1'b0;
      win_go = 1'b0;
      win_end = 1'b0;
      lf = 8'h2E;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      // every divisor used gives zero rate error
      setcfg(SRC_MASTER, 1'b1, 1'b0, 16'h0001);
      measure(16'h0500, 16'h00A0);
      lf = lfsr(lf);
      setcfg(SRC_MASTER, lf[0], 1'b0, 16'h0005);
      measure(16'h0100, lf[0] ? 16'h0020 : 16'h0010);
      setcfg(SRC_MASTER, 1'b0, 1'b0, 16'h0000);
      measure(16'h0000, 16'h0000);
      setcfg(SRC_MASTER_DIV, 1'b1, 1'b0, 16'h0002);
      measure(16'h0050, 16'h000A);
      setcfg(SRC_MASTER, 1'b0, 1'b1, 16'h0004);
      measure(16'h0140, 16'h0140);
      run <= 1'b1;
      setcfg(SRC_EXT, 1'b0, 1'b1, 16'h0000);
      measure(16'h0020, 16'h0020);
      setcfg(SRC_EXT_ALT, 1'b1, 1'b0, 16'h0002);
      measure(16'h0010, 16'h0002);
      // write while gated, run after ungating
      periph_clk_en <= 1'b0;
      setcfg(SRC_MASTER, 1'b1, 1'b0, 16'h0001);
      measure(16'h0000, 16'h0000);
      periph_clk_en <= 1'b1;
      measure(16'h0500, 16'h00A0);
      repeat (4) @(posedge mclk);
      conclude();
   end
endmodule // test_usart_baud_clock_generator
